// File: verilog/dph_direct_page.sv
// Direct-page host registers: events, access pointer, mailbox flags
`timescale 1ns/1ns
`default_nettype none
module dph_direct_page #(
  parameter int QUEUE_DEPTH = dph_pkg::EVQ_DEPTH
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic hostSel,
  input wire logic hostWr,
  input wire logic [dph_pkg::ADDR_W-1:0] hostAddr,
  input wire logic [dph_pkg::DATA_W-1:0] hostWdata,
  output logic [dph_pkg::DATA_W-1:0] hostRdata,
  output logic hostRdValid,
  input wire logic pagedStart,
  input wire logic [dph_pkg::PTR_W-1:0] pagedStartOffset,
  input wire logic pagedStep,
  output logic [dph_pkg::PTR_W-1:0] nextAccessPointer,
  input wire logic fwEventValid,
  output logic fwEventReady,
  input wire logic [dph_pkg::CODE_W-1:0] fwEventCode,
  input wire logic [dph_pkg::DATA_W-1:0] fwEventArg,
  input wire logic [dph_pkg::DATA_W-1:0] faultLiveStatus,
  input wire logic fwCmdRelease,
  input wire logic fwRspRelease,
  output logic [1:0] mailboxOwnership,
  input wire logic fwWr,
  input wire logic [dph_pkg::ADDR_W-1:0] fwAddr,
  input wire logic [dph_pkg::DATA_W-1:0] fwWdata,
  output logic [dph_pkg::DATA_W-1:0] faultInterruptMask
);
  import dph_pkg::*;

  // ----------------------------------------
  // Access decode
  // ----------------------------------------
  wire hostRd = hostSel && !hostWr;
  wire hostWrEn = hostSel && hostWr;
  wire rdInd = hostRd && (hostAddr == OFS_IND);
  wire wrPtr = hostWrEn && (hostAddr == OFS_PTR);
  wire wrMbox = hostWrEn && (hostAddr == OFS_MBOX);
  wire inStore = (hostAddr <= OFS_STORE_END);
  wire [4:0] hostIdx = hostAddr[4:0];
  wire [4:0] fwIdx = fwAddr[4:0];
  wire hostStoreWr = hostWrEn && (
    (hostAddr >= OFS_SUM_HI && hostAddr <= OFS_CLKA) ||
    hostAddr == OFS_REFCFG || hostAddr == OFS_MASK ||
    hostAddr == OFS_ENTRY_HI || hostAddr == OFS_ENTRY_LO);
  wire fwStoreWr = fwWr && (fwAddr <= OFS_STORE_END) &&
    (fwAddr >= OFS_SUM_HI) && (fwAddr != OFS_LIVE);

  // ----------------------------------------
  // Stored words
  // ----------------------------------------
  logic [DATA_W-1:0] store_q [0:STORE_N-1];
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      for (int i = 0; i < STORE_N; i++)
      begin
        store_q[i] <= WORD_ZERO;
      end
    end
    else if (hostStoreWr)
    begin
      store_q[hostIdx] <= hostWdata;
    end
    else if (fwStoreWr)
    begin
      store_q[fwIdx] <= fwWdata;
    end
  end
  assign faultInterruptMask = store_q[OFS_MASK[4:0]];

  // ----------------------------------------
  // Fault transition capture
  // ----------------------------------------
  logic [DATA_W-1:0] live_q;
  logic [DATA_W-1:0] faultEvt_q;
  logic [DATA_W-1:0] faultEvt_d;
  wire [DATA_W-1:0] faultChange = faultLiveStatus ^ live_q;
  wire [CODE_W-1:0] faultShown = faultEvt_q[CODE_W-1:0] &
    ~faultInterruptMask[CODE_W-1:0];
  wire faultPending = (faultShown != '0);

  // ----------------------------------------
  // Event queue
  // ----------------------------------------
  logic qValid;
  logic [EVQ_W-1:0] qHead;
  wire qPop = rdInd && !faultPending && qValid;
  dph_event_fifo #(
    .WIDTH(EVQ_W),
    .DEPTH(QUEUE_DEPTH)
  ) u_evq (
    .mclk(mclk),
    .rst(rst),
    .pushValid(fwEventValid),
    .pushReady(fwEventReady),
    .pushData({fwEventCode, fwEventArg}),
    .popValid(qValid),
    .popReady(qPop),
    .popData(qHead)
  );

  // ----------------------------------------
  // Indication and parameter
  // ----------------------------------------
  wire [DATA_W-1:0] indWord = faultPending ? {1'b1, faultShown} :
    qValid ? {1'b0, qHead[EVQ_W-1:DATA_W]} :
    WORD_ZERO;
  wire [DATA_W-1:0] paramNext = faultPending ? faultEvt_q :
    qValid ? qHead[DATA_W-1:0] : WORD_ZERO;
  wire [DATA_W-1:0] faultClr = (rdInd && faultPending) ?
    {1'b0, faultShown} : WORD_ZERO;
  // New transition outranks the clear in the same cycle
  assign faultEvt_d = (faultEvt_q & ~faultClr) | faultChange;
  logic [DATA_W-1:0] param_q;
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      live_q <= WORD_ZERO;
      faultEvt_q <= WORD_ZERO;
      param_q <= WORD_ZERO;
    end
    else
    begin
      live_q <= faultLiveStatus;
      faultEvt_q <= faultEvt_d;
      if (rdInd)
      begin
        param_q <= paramNext;
      end
    end
  end

  // ----------------------------------------
  // Mailbox access pointer
  // ----------------------------------------
  logic [PTR_W-1:0] ptr_q;
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      ptr_q <= PTR_RESET;
    end
    else if (wrPtr)
    begin
      ptr_q <= hostWdata[PTR_W-1:0];
    end
    else if (pagedStart)
    begin
      ptr_q <= pagedStartOffset;
    end
    else if (pagedStep)
    begin
      ptr_q <= ptr_q + 1'b1;
    end
  end
  assign nextAccessPointer = ptr_q;

  // ----------------------------------------
  // Mailbox ownership
  // ----------------------------------------
  logic [1:0] mbox_q;
  wire [1:0] hostSet = wrMbox ? hostWdata[1:0] : 2'h0;
  wire [1:0] fwClr = {fwRspRelease, fwCmdRelease};
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      mbox_q <= MBOX_RESET;
    end
    else
    begin
      mbox_q <= (mbox_q & ~fwClr) | hostSet;
    end
  end
  assign mailboxOwnership = mbox_q;

  // ----------------------------------------
  // Read data path
  // ----------------------------------------
  logic [DATA_W-1:0] rdMux;
  always_comb
  begin
    rdMux = WORD_ZERO;
    if (hostAddr >= OFS_RESERVED_BITS_BASE)
    begin
      rdMux = WORD_ZERO;
    end
    else if (hostAddr == OFS_IND)
    begin
      rdMux = indWord;
    end
    else if (hostAddr == OFS_PARAM)
    begin
      rdMux = param_q;
    end
    else if (hostAddr == OFS_PTR)
    begin
      rdMux = {6'h00, ptr_q};
    end
    else if (hostAddr == OFS_MBOX)
    begin
      rdMux = {14'h0000, mbox_q};
    end
    else if (hostAddr == OFS_LIVE)
    begin
      rdMux = faultLiveStatus;
    end
    else if (hostAddr == OFS_CAUSE)
    begin
      rdMux = {12'h000, store_q[hostIdx][CAUSE_W-1:0]};
    end
    else if (inStore)
    begin
      rdMux = store_q[hostIdx];
    end
  end
  logic [DATA_W-1:0] rdata_q;
  logic rdValid_q;
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      rdata_q <= WORD_ZERO;
      rdValid_q <= 1'b0;
    end
    else
    begin
      rdValid_q <= hostRd;
      if (hostRd)
      begin
        rdata_q <= rdMux;
      end
    end
  end
  assign hostRdata = rdata_q;
  assign hostRdValid = rdValid_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_ind_read;
    rdInd && faultPending;
  endsequence
  sequence s_param_read;
    hostRd && hostAddr == OFS_PARAM;
  endsequence
  sequence s_ptr_resume;
    (pagedStep && !wrPtr && !pagedStart)[*2];
  endsequence
  a_idle_reads_zero: assert property (
    rdInd && !faultPending && !qValid |=> hostRdata == WORD_ZERO)
    else $error("idle indication not zero");
  a_fault_src_bit: assert property (
    s_ind_read |=> hostRdata[BIT_SRC] && hostRdata[CODE_W-1:0] != '0)
    else $error("fault source bit wrong");
  a_fault_snapshot: assert property (
    s_ind_read |=> param_q == $past(faultEvt_q))
    else $error("fault parameter not snapshot");
  a_fault_clear: assert property (
    s_ind_read ##1 !(|$past(faultChange)) |->
      (faultEvt_q[CODE_W-1:0] & $past(faultShown)) == '0)
    else $error("reported fault not cleared");
  a_param_stable: assert property (
    s_param_read ##0 !rdInd |=> $stable(param_q) && hostRdata == $past(param_q))
    else $error("parameter read changed state");
  a_queue_code: assert property (
    rdInd && !faultPending && qValid |=>
      !hostRdata[BIT_SRC] && param_q == $past(qHead[DATA_W-1:0]))
    else $error("queue event misreported");
  a_mbox_zero: assert property (
    wrMbox && fwClr == 2'h0 |=> mbox_q == ($past(mbox_q) | $past(hostWdata[1:0])))
    else $error("ownership write wrong");
  a_mbox_release: assert property (
    fwCmdRelease && !(wrMbox && hostWdata[BIT_CMD_BOX]) |=> !mbox_q[BIT_CMD_BOX])
    else $error("command box not released");
  a_ptr_restore: assert property (
    wrPtr ##1 s_ptr_resume |=>
      ptr_q == $past(hostWdata[PTR_W-1:0], 3) + 10'h002)
    else $error("pointer did not resume");
  a_reserved_bits_zero: assert property (
    hostRd && hostAddr >= OFS_RESERVED_BITS_BASE |=> hostRdata == WORD_ZERO)
    else $error("reserved offset not zero");
  a_ptr_load: assert property (
    wrPtr |=> ptr_q == $past(hostWdata[PTR_W-1:0]))
    else $error("pointer write not taken");
  a_ptr_step: assert property (
    pagedStep && !wrPtr && !pagedStart |=> ptr_q == $past(ptr_q) + 10'h001)
    else $error("pointer did not advance");
  a_rsp_release: assert property (
    fwRspRelease && !(wrMbox && hostWdata[BIT_RSP_BOX]) |=> !mbox_q[BIT_RSP_BOX])
    else $error("response box not released");
  a_fault_set_wins: assert property (
    (|faultChange) |=> (faultEvt_q & $past(faultChange)) == $past(faultChange))
    else $error("fault transition lost");
  a_read_answer: assert property (
    hostRd |=> hostRdValid)
    else $error("read not answered");
  a_cause_width: assert property (
    hostRd && hostAddr == OFS_CAUSE |=> hostRdata[DATA_W-1:CAUSE_W] == '0)
    else $error("reset cause too wide");
  a_mbox_readback: assert property (
    hostRd && hostAddr == OFS_MBOX |=> hostRdata == {14'h0000, $past(mbox_q)})
    else $error("ownership read wrong");
  a_live_read: assert property (
    hostRd && hostAddr == OFS_LIVE |=> hostRdata == $past(faultLiveStatus))
    else $error("live status read wrong");
endmodule : dph_direct_page
`default_nettype wire

// File: verilog/dph_pkg.sv
// Constants for the direct-page host register bank
`default_nettype none
package dph_pkg;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 7;
  localparam int PTR_W = 10;
  localparam int CODE_W = 15;
  localparam int CAUSE_W = 4;
  localparam int STORE_N = 32;
  localparam logic [6:0] OFS_IND = 7'h00;
  localparam logic [6:0] OFS_PARAM = 7'h01;
  localparam logic [6:0] OFS_PTR = 7'h02;
  localparam logic [6:0] OFS_MBOX = 7'h03;
  localparam logic [6:0] OFS_SUM_HI = 7'h04;
  localparam logic [6:0] OFS_SUM_LO = 7'h05;
  localparam logic [6:0] OFS_BASE_HI = 7'h06;
  localparam logic [6:0] OFS_BASE_LO = 7'h07;
  localparam logic [6:0] OFS_CLKB = 7'h08;
  localparam logic [6:0] OFS_CLKA = 7'h09;
  localparam logic [6:0] OFS_CLOCK_STATUS = 7'h0a;
  localparam logic [6:0] OFS_REFCFG = 7'h0b;
  localparam logic [6:0] OFS_LIVE = 7'h0c;
  localparam logic [6:0] OFS_MASK = 7'h0d;
  localparam logic [6:0] OFS_SENSE_HI = 7'h14;
  localparam logic [6:0] OFS_SENSE_LO = 7'h15;
  localparam logic [6:0] OFS_CAUSE = 7'h16;
  localparam logic [6:0] OFS_ENTRY_HI = 7'h18;
  localparam logic [6:0] OFS_ENTRY_LO = 7'h19;
  localparam logic [6:0] OFS_STORE_END = 7'h1f;
  localparam logic [6:0] OFS_RESERVED_BITS_BASE = 7'h78;
  localparam int BIT_SRC = 15;
  localparam int BIT_CMD_BOX = 0;
  localparam int BIT_RSP_BOX = 1;
  localparam logic [1:0] MBOX_RESET = 2'h3;
  localparam logic [15:0] WORD_ZERO = 16'h0000;
  localparam logic [15:0] MASK_RESET = 16'h0000;
  localparam logic [9:0] PTR_RESET = 10'h000;
  localparam int EVQ_DEPTH = 8;
  localparam int EVQ_W = 31;
endpackage : dph_pkg
`default_nettype wire

// File: verilog/dph_event_fifo.sv
// Arrival-order queue of pending firmware events
`timescale 1ns/1ns
`default_nettype none
module dph_event_fifo #(
  parameter int WIDTH = dph_pkg::EVQ_W,
  parameter int DEPTH = dph_pkg::EVQ_DEPTH
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic pushValid,
  output logic pushReady,
  input wire logic [WIDTH-1:0] pushData,
  output logic popValid,
  input wire logic popReady,
  output logic [WIDTH-1:0] popData
);
  import dph_pkg::*;
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [AW-1:0] wrPtr_q;
  logic [AW-1:0] rdPtr_q;
  logic [AW:0] count_q;
  wire doPush = pushValid && pushReady;
  wire doPop = popValid && popReady;
  wire [AW-1:0] wrNext = (wrPtr_q == AW'(DEPTH-1)) ? '0 : wrPtr_q + 1'b1;
  wire [AW-1:0] rdNext = (rdPtr_q == AW'(DEPTH-1)) ? '0 : rdPtr_q + 1'b1;
  assign pushReady = (count_q != (AW+1)'(DEPTH));
  assign popValid = (count_q != '0);
  assign popData = mem[rdPtr_q];
  always_ff @(posedge mclk)
  begin
    if (doPush)
    begin
      mem[wrPtr_q] <= pushData;
    end
  end
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end
    else
    begin
      if (doPush)
      begin
        wrPtr_q <= wrNext;
      end
      if (doPop)
      begin
        rdPtr_q <= rdNext;
      end
      if (doPush && !doPop)
      begin
        count_q <= count_q + 1'b1;
      end
      else if (doPop && !doPush)
      begin
        count_q <= count_q - 1'b1;
      end
    end
  end
endmodule : dph_event_fifo
`default_nettype wire

// File: bench/dph_host_model.sv
// Host processor model issuing direct-page word accesses
`timescale 1ns/1ns
`default_nettype none
module dph_host_model (
  input wire logic mclk,
  output logic hostSel,
  output logic hostWr,
  output logic [dph_pkg::ADDR_W-1:0] hostAddr,
  output logic [dph_pkg::DATA_W-1:0] hostWdata,
  input wire logic [dph_pkg::DATA_W-1:0] hostRdata,
  input wire logic hostRdValid
);
  import dph_pkg::*;
  initial
  begin
    hostSel = 1'b0;
    hostWr = 1'b0;
    hostAddr = 7'h7f;
    hostWdata = 16'hffff;
  end
  // One word write; callers keep reserved bits zero
  task wr(input logic [6:0] a, input logic [15:0] d);
    @(posedge mclk);
    hostSel <= 1'b1;
    hostWr <= 1'b1;
    hostAddr <= a;
    hostWdata <= d;
    @(posedge mclk);
    hostSel <= 1'b0;
    hostWr <= 1'b0;
    hostAddr <= ~a;
    hostWdata <= ~d;
  endtask : wr
  // One word read, answer registered on the taking edge and sampled 1 ns after it
  task rd(input logic [6:0] a, output logic [15:0] d, output logic v);
    @(posedge mclk);
    hostSel <= 1'b1;
    hostWr <= 1'b0;
    hostAddr <= a;
    @(posedge mclk);
    hostSel <= 1'b0;
    hostAddr <= ~a;
    #1;
    d = hostRdata;
    v = hostRdValid;
  endtask : rd
endmodule : dph_host_model
`default_nettype wire

// File: bench/tb_top.sv
// Self-checking bench for the direct-page host register bank
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import dph_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  wire logic hostSel;
  wire logic hostWr;
  wire logic [ADDR_W-1:0] hostAddr;
  wire logic [DATA_W-1:0] hostWdata;
  logic [DATA_W-1:0] hostRdata;
  logic hostRdValid;
  logic pagedStart = 1'b0;
  logic [PTR_W-1:0] pagedStartOffset = 10'h000;
  logic pagedStep = 1'b0;
  logic [PTR_W-1:0] nextAccessPointer;
  logic fwEventValid = 1'b0;
  logic fwEventReady;
  logic [CODE_W-1:0] fwEventCode = 15'h0000;
  logic [DATA_W-1:0] fwEventArg = 16'h0000;
  logic [DATA_W-1:0] faultLiveStatus = 16'h0000;
  logic fwCmdRelease = 1'b0;
  logic fwRspRelease = 1'b0;
  logic [1:0] mailboxOwnership;
  logic fwWr = 1'b0;
  logic [ADDR_W-1:0] fwAddr = 7'h00;
  logic [DATA_W-1:0] fwWdata = 16'h0000;
  logic [DATA_W-1:0] faultInterruptMask;
  logic [15:0] saved;
  logic savedValid;
  int miscompares = 0;
  int samples_checked = 0;
  int cycles = 0;

  always #20 mclk = ~mclk;

  dph_direct_page #(.QUEUE_DEPTH(8)) i_dph_direct_page (.mclk(mclk), .rst(rst),
    .hostSel(hostSel), .hostWr(hostWr), .hostAddr(hostAddr), .hostWdata(hostWdata),
    .hostRdata(hostRdata), .hostRdValid(hostRdValid), .pagedStart(pagedStart),
    .pagedStartOffset(pagedStartOffset), .pagedStep(pagedStep),
    .nextAccessPointer(nextAccessPointer), .fwEventValid(fwEventValid),
    .fwEventReady(fwEventReady), .fwEventCode(fwEventCode), .fwEventArg(fwEventArg),
    .faultLiveStatus(faultLiveStatus), .fwCmdRelease(fwCmdRelease),
    .fwRspRelease(fwRspRelease), .mailboxOwnership(mailboxOwnership), .fwWr(fwWr),
    .fwAddr(fwAddr), .fwWdata(fwWdata), .faultInterruptMask(faultInterruptMask));

  dph_host_model i_dph_host_model (.mclk(mclk), .hostSel(hostSel), .hostWr(hostWr),
    .hostAddr(hostAddr), .hostWdata(hostWdata), .hostRdata(hostRdata),
    .hostRdValid(hostRdValid));

  // ----
  // Shared tasks
  // ----
  task check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task rdchk(input logic [6:0] a, input logic [15:0] exp);
    logic [15:0] d;
    logic v;
    i_dph_host_model.rd(a, d, v);
    check({15'h0000, v}, 16'h0001);
    check(d, exp);
  endtask : rdchk
  task wr(input logic [6:0] a, input logic [15:0] d);
    i_dph_host_model.wr(a, d);
  endtask : wr
  task fwStore(input logic [6:0] a, input logic [15:0] d);
    @(posedge mclk);
    fwWr <= 1'b1;
    fwAddr <= a;
    fwWdata <= d;
    @(posedge mclk);
    fwWr <= 1'b0;
  endtask : fwStore
  task stop_test;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : stop_test

  always @(posedge mclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      miscompares++;
      stop_test();
    end
  end

  // ----
  // Tests
  // ----
  initial
  begin
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    rdchk(OFS_IND, 16'h0000);
    rdchk(OFS_MBOX, 16'h0003);
    rdchk(OFS_PTR, 16'h0000);
    rdchk(7'h0e, 16'h0000);
    rdchk(7'h7c, 16'h0000);
    $display("test reset done");
    check({15'h0000, fwEventReady}, 16'h0001);
    for (int i = 0; i < EVQ_DEPTH; i++)
    begin
      @(posedge mclk);
      fwEventValid <= 1'b1;
      fwEventCode <= 15'h0010 + 15'(i);
      fwEventArg <= 16'ha000 + 16'(i);
    end
    @(posedge mclk);
    fwEventValid <= 1'b0;
    #1 check({15'h0000, fwEventReady}, 16'h0000);
    for (int i = 0; i < EVQ_DEPTH; i++)
    begin
      rdchk(OFS_IND, 16'h0010 + 16'(i));
      rdchk(OFS_PARAM, 16'ha000 + 16'(i));
      rdchk(OFS_PARAM, 16'ha000 + 16'(i));
    end
    rdchk(OFS_IND, 16'h0000);
    rdchk(OFS_PARAM, 16'h0000);
    check({15'h0000, fwEventReady}, 16'h0001);
    $display("test queue done");
    wr(OFS_MASK, 16'h0002);
    @(posedge mclk);
    faultLiveStatus <= 16'h0003;
    fwEventValid <= 1'b1;
    fwEventCode <= 15'h0077;
    fwEventArg <= 16'h5555;
    @(posedge mclk);
    fwEventValid <= 1'b0;
    repeat (2) @(posedge mclk);
    check(faultInterruptMask, 16'h0002);
    rdchk(OFS_MASK, 16'h0002);
    rdchk(OFS_LIVE, 16'h0003);
    rdchk(OFS_IND, 16'h8001);
    rdchk(OFS_PARAM, 16'h0003);
    rdchk(OFS_IND, 16'h0077);
    rdchk(OFS_PARAM, 16'h5555);
    rdchk(OFS_IND, 16'h0000);
    $display("test fault done");
    wr(OFS_PTR, 16'h0123);
    rdchk(OFS_PTR, 16'h0123);
    @(posedge mclk);
    pagedStep <= 1'b1;
    repeat (2) @(posedge mclk);
    pagedStep <= 1'b0;
    #1 check({6'h00, nextAccessPointer}, 16'h0125);
    i_dph_host_model.rd(OFS_PTR, saved, savedValid);
    check({15'h0000, savedValid}, 16'h0001);
    check(saved, 16'h0125);
    @(posedge mclk);
    pagedStart <= 1'b1;
    @(posedge mclk);
    pagedStart <= 1'b0;
    #1 check({6'h00, nextAccessPointer}, 16'h0000);
    wr(OFS_PTR, saved);
    pagedStep <= 1'b1;
    repeat (2) @(posedge mclk);
    pagedStep <= 1'b0;
    rdchk(OFS_PTR, 16'h0127);
    @(posedge mclk);
    pagedStart <= 1'b1;
    pagedStartOffset <= 10'h3ff;
    @(posedge mclk);
    pagedStart <= 1'b0;
    pagedStep <= 1'b1;
    @(posedge mclk);
    pagedStep <= 1'b0;
    #1 check({6'h00, nextAccessPointer}, 16'h0000);
    $display("test pointer done");
    wr(OFS_MBOX, 16'h0000);
    rdchk(OFS_MBOX, 16'h0003);
    @(posedge mclk);
    fwCmdRelease <= 1'b1;
    @(posedge mclk);
    fwCmdRelease <= 1'b0;
    rdchk(OFS_MBOX, 16'h0002);
    @(posedge mclk);
    fwRspRelease <= 1'b1;
    @(posedge mclk);
    fwRspRelease <= 1'b0;
    #1 check({14'h0000, mailboxOwnership}, 16'h0000);
    wr(OFS_MBOX, 16'h0000);
    rdchk(OFS_MBOX, 16'h0000);
    wr(OFS_MBOX, 16'h0001);
    rdchk(OFS_MBOX, 16'h0001);
    wr(OFS_MBOX, 16'h0002);
    rdchk(OFS_MBOX, 16'h0003);
    $display("test mailbox done");
    fwStore(OFS_SENSE_HI, 16'h1234);
    fwStore(OFS_SENSE_LO, 16'h5678);
    fwStore(OFS_CAUSE, 16'h00a5);
    wr(OFS_SENSE_HI, 16'h0000);
    wr(OFS_SUM_HI, 16'hbeef);
    wr(OFS_ENTRY_HI, 16'h0012);
    wr(OFS_ENTRY_LO, 16'h3456);
    rdchk(OFS_SENSE_HI, 16'h1234);
    rdchk(OFS_SENSE_LO, 16'h5678);
    rdchk(OFS_CAUSE, 16'h0005);
    rdchk(OFS_SUM_HI, 16'hbeef);
    rdchk(OFS_ENTRY_HI, 16'h0012);
    rdchk(OFS_ENTRY_LO, 16'h3456);
    $display("test stored done");
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
